// ---- design/clock_enable_control_defines.svh ----
// constants for the clock enable control block
`ifndef CLOCK_ENABLE_CONTROL_DEFINES_SVH
`define CLOCK_ENABLE_CONTROL_DEFINES_SVH
// ******************************************************************
// register offsets (byte addresses)
// ******************************************************************
`define CEC_CTRL_OFS      8'h00
`define CEC_CFG_OFS       8'h04
`define CEC_MULT_OFS      8'h08
`define CEC_STAT_OFS      8'h0C
// ******************************************************************
// field positions
// ******************************************************************
`define CEC_CTRL_INT_ON   0
`define CEC_CTRL_EXT_ON   1
`define CEC_CTRL_BUS_EXT  2
`define CEC_CFG_OSC_STOP  0
`define CEC_CFG_EXT_ALLOW 1
`define CEC_CFG_XTAL      2
// ******************************************************************
// reset values
// ******************************************************************
`define CEC_CTRL_RST      3'h1
`define CEC_CFG_RST       3'h0
`define CEC_MULT_RST      7'h01
// ******************************************************************
// timing
// ******************************************************************
`define CEC_CLK_HZ        40000000
`define CEC_BASE_HZ       307200
`define CEC_BUS_STEP_HZ   76800
`define CEC_BASE_HALF     ((`CEC_CLK_HZ / `CEC_BASE_HZ) / 2)
`endif

// ---- design/clock_enable_control_pkg.sv ----
// types shared by the clock enable control block
package clock_enable_control_pkg;
    // ******************************************************************
    // bus request carrier
    // ******************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic xtal;
        logic ext_allow;
        logic osc_stop;
    } cfg_t;

    typedef struct packed {
        logic bus_ext;
        logic ext_on;
        logic int_on;
    } ctrl_t;
endpackage : clock_enable_control_pkg

// ---- design/clock_enable_control.sv ----
// clock enable, gating and ratio logic of the on-chip clock generator
`timescale 1ns/100ps
`include "clock_enable_control_defines.svh"

module clock_enable_control #(
    parameter int MULT_W = 7
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        stop_mode_i,
    input  wire logic        ext_clk_pin_i,
    output logic             generator_stop_o,
    output logic             internal_gen_enable_o,
    output logic             external_gen_enable_o,
    output logic             first_osc_pin_port_enable_o,
    output logic             second_osc_pin_port_enable_o,
    output logic             internal_clock_o,
    output logic             low_freq_base_clock_o,
    output logic             external_clock_o,
    output logic             oscillator_output_clock_o,
    output logic             generator_output_clock_o,
    output logic             bus_clock_o,
    output logic             timebase_clock_o
);
    localparam int BASE_HALF = `CEC_BASE_HALF;
    localparam int BH_W      = $clog2(BASE_HALF + 1);

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    // stop mode and the external pin arrive asynchronously to clk_i
    logic [1:0] stop_sync_r;
    logic [1:0] stop_sync_nxt;
    logic [1:0] ext_sync_r;
    logic [1:0] ext_sync_nxt;

    // first stage feeds only the second stage
    always_comb begin
        stop_sync_nxt = {stop_sync_r[0], stop_mode_i};
        ext_sync_nxt  = {ext_sync_r[0], ext_clk_pin_i};
    end

    // both stages reset low, so no false stop request follows reset;
    // a metastable first stage is never read by the logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_sync_r <= 2'h0;
            ext_sync_r  <= 2'h0;
        end else begin
            stop_sync_r <= stop_sync_nxt;
            ext_sync_r  <= ext_sync_nxt;
        end
    end

    // ******************************************************************
    // register file over classic wishbone
    // ******************************************************************
    clock_enable_control_pkg::wb_req_t req;
    clock_enable_control_pkg::ctrl_t   ctrl_r;
    clock_enable_control_pkg::ctrl_t   ctrl_nxt;
    clock_enable_control_pkg::cfg_t    cfg_r;
    clock_enable_control_pkg::cfg_t    cfg_nxt;
    logic [MULT_W-1:0]                 mult_r;
    logic [MULT_W-1:0]                 mult_nxt;
    logic                              ack_nxt;
    logic [31:0]                       rdat_nxt;
    logic                              wr;
    logic                              stop_int;
    // timebase choice as seen in the status word, driven by the selection
    logic                              timebase_sel_ext;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    // a write lands at the edge where the master samples ack high, so a
    // request dropped before its answer leaves the registers untouched
    assign wr  = req.cyc && req.stb && req.we && wb_ack_o && req.sel[0];

    // one wait state: ack one cycle after the request, dropped the next
    always_comb begin
        ctrl_nxt = ctrl_r;
        cfg_nxt  = cfg_r;
        mult_nxt = mult_r;
        ack_nxt  = req.cyc && req.stb && !wb_ack_o;
        rdat_nxt = 32'h0000_0000;
        if (wr && req.adr == `CEC_CFG_OFS) begin
            cfg_nxt = clock_enable_control_pkg::cfg_t'(req.dat[2:0]);
        end
        if (wr && req.adr == `CEC_MULT_OFS) begin
            mult_nxt = req.dat[MULT_W-1:0];
        end
        if (wr && req.adr == `CEC_CTRL_OFS) begin
            ctrl_nxt = clock_enable_control_pkg::ctrl_t'(req.dat[2:0]);
        end
        // external-on refused while external clocking is not allowed
        if (!cfg_nxt.ext_allow) begin
            ctrl_nxt.ext_on = 1'b0;
        end
        // read data is registered together with ack and stands with it
        case (req.adr)
            `CEC_CTRL_OFS: rdat_nxt = {29'h0, ctrl_r};
            `CEC_CFG_OFS:  rdat_nxt = {29'h0, cfg_r};
            `CEC_MULT_OFS: rdat_nxt = {{(32-MULT_W){1'b0}}, mult_r};
            `CEC_STAT_OFS: rdat_nxt = {27'h0, timebase_sel_ext,
                                       generator_stop_o,
                                       external_gen_enable_o,
                                       internal_gen_enable_o,
                                       stop_sync_r[1]};
            default:       rdat_nxt = 32'h0000_0000;
        endcase
    end

    // register state and the bus answer; reset values are the power-up
    // configuration, internal generator on and external sources off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= clock_enable_control_pkg::ctrl_t'(`CEC_CTRL_RST);
            cfg_r    <= clock_enable_control_pkg::cfg_t'(`CEC_CFG_RST);
            mult_r   <= MULT_W'(`CEC_MULT_RST);
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            cfg_r    <= cfg_nxt;
            mult_r   <= mult_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= rdat_nxt;
        end
    end

    // ******************************************************************
    // enables and pin hand-back
    // ******************************************************************
    logic stop_nxt;
    logic ien_nxt;
    logic een_nxt;
    logic pc1_nxt;
    logic pc2_nxt;

    // stop reaches the enables and the clocks at one and the same edge
    always_comb begin
        // stop only in stop mode and only without osc-in-stop
        stop_int = stop_sync_r[1] && !cfg_r.osc_stop;
        stop_nxt = stop_int;
        ien_nxt  = ctrl_r.int_on && !stop_int;
        een_nxt  = ctrl_r.ext_on && !stop_int;
        // pin enables ignore stop so the pins stay claimed while stopped
        pc1_nxt  = !ctrl_r.ext_on;
        pc2_nxt  = !(ctrl_r.ext_on && cfg_r.xtal);
    end

    // port enables reset high: the first pin belongs to the port until
    // software asks for the external clock, the second until it asks for it
    // with the crystal selected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            generator_stop_o             <= 1'b0;
            internal_gen_enable_o        <= 1'b0;
            external_gen_enable_o        <= 1'b0;
            first_osc_pin_port_enable_o  <= 1'b1;
            second_osc_pin_port_enable_o <= 1'b1;
        end else begin
            generator_stop_o             <= stop_nxt;
            internal_gen_enable_o        <= ien_nxt;
            external_gen_enable_o        <= een_nxt;
            first_osc_pin_port_enable_o  <= pc1_nxt;
            second_osc_pin_port_enable_o <= pc2_nxt;
        end
    end

    // ******************************************************************
    // internal clock and base clock
    // ******************************************************************
    // the loop is modelled by a fixed half period: the base is nominal and
    // the internal clock runs N times faster, limited by the system clock
    // limitation: once the factor exceeds the base half period the count
    // clamps at one system cycle and no longer follows the factor
    logic [BH_W-1:0]   icnt_r;
    logic [BH_W-1:0]   icnt_nxt;
    logic [BH_W-1:0]   ihalf;
    logic [MULT_W:0]   ndiv_r;
    logic [MULT_W:0]   ndiv_nxt;
    logic              internal_clock_nxt;
    logic              low_freq_base_clock_nxt;
    logic              bypass;

    always_comb begin
        bypass   = mult_r <= MULT_W'(1);
        ihalf    = bypass ? BH_W'(BASE_HALF)
                          : BH_W'(BASE_HALF / int'(mult_r));
        if (ihalf == '0) begin
            ihalf = BH_W'(1);
        end
        icnt_nxt  = icnt_r;
        ndiv_nxt  = ndiv_r;
        internal_clock_nxt  = internal_clock_o;
        low_freq_base_clock_nxt = low_freq_base_clock_o;
        if (!ien_nxt) begin
            // generator off: both clocks held low
            icnt_nxt  = '0;
            ndiv_nxt  = '0;
            internal_clock_nxt  = 1'b0;
            low_freq_base_clock_nxt = 1'b0;
        end else if (icnt_r + BH_W'(1) >= ihalf) begin
            icnt_nxt = '0;
            internal_clock_nxt = !internal_clock_o;
            if (bypass) begin
                low_freq_base_clock_nxt = !internal_clock_o;
            end else if (ndiv_r + (MULT_W+1)'(1) >= {1'b0, mult_r}) begin
                ndiv_nxt  = '0;
                low_freq_base_clock_nxt = !low_freq_base_clock_o;
            end else begin
                ndiv_nxt = ndiv_r + (MULT_W+1)'(1);
            end
        end else begin
            icnt_nxt = icnt_r + BH_W'(1);
        end
    end

    // both clocks reset low, the level of a generator that is off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            icnt_r                <= '0;
            ndiv_r                <= '0;
            internal_clock_o      <= 1'b0;
            low_freq_base_clock_o <= 1'b0;
        end else begin
            icnt_r                <= icnt_nxt;
            ndiv_r                <= ndiv_nxt;
            internal_clock_o      <= internal_clock_nxt;
            low_freq_base_clock_o <= low_freq_base_clock_nxt;
        end
    end

    // ******************************************************************
    // clock selection and ratio dividers
    // ******************************************************************
    logic       external_clock_nxt;
    logic       src_clk;
    logic [1:0] div_r;
    logic [1:0] div_nxt;
    logic       src_d_r;
    logic       tb_nxt;

    always_comb begin
        external_clock_nxt = een_nxt && ext_sync_r[1];
        // bus source chosen by software, base step is 76.8 kHz
        src_clk  = ctrl_r.bus_ext ? external_clock_o
                                  : internal_clock_o;
        // timebase follows the external clock whenever it is running
        timebase_sel_ext = external_gen_enable_o;
        tb_nxt   = timebase_sel_ext ? external_clock_o : internal_clock_o;
        // edges are counted on clk_i, so a source above half its rate
        // would be undercounted; the bus ratio then no longer holds
        div_nxt  = (src_clk && !src_d_r) ? div_r + 2'h1 : div_r;
    end

    // every output is a flop, so each clock lags its source by a cycle;
    // the ratios hold over whole periods, not edge for edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            external_clock_o          <= 1'b0;
            src_d_r                   <= 1'b0;
            div_r                     <= 2'h0;
            oscillator_output_clock_o <= 1'b0;
            generator_output_clock_o  <= 1'b0;
            bus_clock_o               <= 1'b0;
            timebase_clock_o          <= 1'b0;
        end else begin
            external_clock_o          <= external_clock_nxt;
            src_d_r                   <= src_clk;
            div_r                     <= div_nxt;
            oscillator_output_clock_o <= src_clk;
            generator_output_clock_o  <= div_nxt[0];
            bus_clock_o               <= div_nxt[1];
            timebase_clock_o          <= tb_nxt;
        end
    end
endmodule : clock_enable_control

// ---- verif/clock_enable_control_monitor.sv ----
// assertion checker for the clock enable control block
`timescale 1ns/100ps
module clock_enable_control_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stop_mode_i,
    input wire logic generator_stop_o,
    input wire logic internal_gen_enable_o,
    input wire logic first_osc_pin_port_enable_o,
    input wire logic second_osc_pin_port_enable_o,
    input wire logic external_gen_enable_o,
    input wire logic internal_clock_o,
    input wire logic low_freq_base_clock_o,
    input wire logic external_clock_o,
    input wire logic generator_output_clock_o,
    input wire logic bus_clock_o
);
    // ******************************************************************
    // properties
    // ******************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // two cycles of stop, though the enable register falls at the same edge as stop
    property p_int_en;
        generator_stop_o && $past(generator_stop_o) |-> !internal_gen_enable_o;
    endproperty
    a_int_en: assert property (p_int_en) else $error("int en in stop");
    property p_int_low;
        !internal_gen_enable_o && $past(!internal_gen_enable_o)
            |-> !internal_clock_o && !low_freq_base_clock_o;
    endproperty
    a_int_low: assert property (p_int_low) else $error("int clk runs");
    property p_ext_low;
        !external_gen_enable_o [*2] |-> !external_clock_o;
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("ext clk runs");
    property p_run;
        !stop_mode_i [*4] |-> !generator_stop_o;
    endproperty
    a_run: assert property (p_run) else $error("stop outside stop");
    property p_stop_cause;
        $rose(generator_stop_o) |-> $past(stop_mode_i, 2)
            || $past(stop_mode_i, 3) || $past(stop_mode_i, 4);
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("bad stop");
    property p_pin1;
        external_gen_enable_o |-> !first_osc_pin_port_enable_o;
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin1 enabled");
    property p_pin2;
        !second_osc_pin_port_enable_o |-> !first_osc_pin_port_enable_o;
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin2 without ext");
    property p_bus;
        $changed(bus_clock_o) |-> $changed(generator_output_clock_o);
    endproperty
    a_bus: assert property (p_bus) else $error("bus off ratio");
    c_stop: cover property (generator_stop_o);
    c_ext: cover property (external_gen_enable_o);
    c_pin2: cover property (!second_osc_pin_port_enable_o);
endmodule : clock_enable_control_monitor
bind clock_enable_control clock_enable_control_monitor mon (.*);

// ---- verif/clock_enable_control_partner.sv ----
// far-side model: clock edge counter of the system integration unit
`timescale 1ns/100ps
module clock_enable_control_partner (
    input  wire logic       clk_i,
    input  wire logic [4:0] clks_i,
    output int              cnt_o [5]
);
    logic [4:0] last_r = 5'h00;
    // clocks arrive as plain levels, so edges are found on the system clock
    always @(posedge clk_i) begin
        last_r <= clks_i;
        for (int k = 0; k < 5; k++) begin
            if (clks_i[k] && !last_r[k]) cnt_o[k] <= cnt_o[k] + 1;
        end
    end
endmodule : clock_enable_control_partner

// ---- verif/clock_enable_control_test.sv ----
// self-checking bench for the clock enable control block
`timescale 1ns/100ps
`include "clock_enable_control_defines.svh"
module clock_enable_control_test;
    logic        clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, stop_mode_i, ext_clk_pin_i, generator_stop_o;
    logic        internal_gen_enable_o, external_gen_enable_o;
    logic        first_osc_pin_port_enable_o, second_osc_pin_port_enable_o;
    logic        internal_clock_o, low_freq_base_clock_o, external_clock_o;
    logic        oscillator_output_clock_o, generator_output_clock_o;
    logic        bus_clock_o, timebase_clock_o, stop_m;
    int          miscompares, comparisons, ctrl_m, cfg_m, cnt [5];
    int          nv [3] = '{0, 1, 5};
    clock_enable_control dut (.*);
    clock_enable_control_partner sys (.clk_i(clk_i), .cnt_o(cnt),
        .clks_i({low_freq_base_clock_o, internal_clock_o, bus_clock_o,
                 generator_output_clock_o, oscillator_output_clock_o}));
    always #12.5 clk_i = ~clk_i;
    // slow external source, well below the system clock
    always begin
        repeat (3) @(posedge clk_i);
        ext_clk_pin_i <= ~ext_clk_pin_i;
    end
    // ******************************************************************
    // tasks
    // ******************************************************************
    task automatic check(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask : check
    // request held until ack is sampled high, bounded wait
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hF};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        if (n >= 16) miscompares++;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        if (a == `CEC_CFG_OFS) cfg_m = d[2:0];
        if (a == `CEC_CFG_OFS && !d[1]) ctrl_m = ctrl_m & 5;
        if (a == `CEC_CTRL_OFS) ctrl_m = d[2:0] & (cfg_m[1] ? 7 : 5);
    endtask : wr
    task automatic pins;
        logic st, ie, ee;
        st = stop_m && !cfg_m[0];
        ie = ctrl_m[0] && !st;
        ee = ctrl_m[1] && !st;
        repeat (8) @(posedge clk_i);
        check("stop", generator_stop_o, st);
        check("int_en", internal_gen_enable_o, ie);
        check("ext_en", external_gen_enable_o, ee);
        check("pin1", first_osc_pin_port_enable_o, !ctrl_m[1]);
        check("pin2", second_osc_pin_port_enable_o,
              !(ctrl_m[1] && cfg_m[2]));
        if (!ie) check("int_clk", {internal_clock_o, low_freq_base_clock_o}, 0);
        if (!ee) check("ext_clk", external_clock_o, 0);
        if (!ie && !ee) check("tb", timebase_clock_o, 0);
        wb(1'b0, `CEC_CTRL_OFS, 0);
        check("ctrl", rd, ctrl_m);
        wb(1'b0, `CEC_STAT_OFS, 0);
        check("stat", rd, {ee, st, ee, ie, stop_m});
    endtask : pins
    task automatic ratio(input int n);
        int c [5];
        int m;
        m = n > 1 ? n : 1;
        wr(`CEC_MULT_OFS, 32'hFFFF_FF80 | n);
        wb(1'b0, `CEC_MULT_OFS, 0);
        check("mult", rd, n);
        repeat (200) @(posedge clk_i);
        c = cnt;
        repeat (3000) @(posedge clk_i);
        m = (cnt[3] - c[3]) - m * (cnt[4] - c[4]);
        check("base", m >= -6 && m <= 6, 1);
        m = (cnt[0] - c[0]) - 4 * (cnt[2] - c[2]);
        check("bus", m >= -4 && m <= 4 && cnt[2] > c[2], 1);
    endtask : ratio
    task automatic stop_test;
        $display("mismatches %0d of %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, stop_mode_i, ext_clk_pin_i} = 6'h20;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 0;
        ctrl_m = `CEC_CTRL_RST;
        cfg_m = 0;
        stop_m = 1'b0;
        void'($urandom(66672));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        pins;
        wb(1'b0, `CEC_MULT_OFS, 0);
        check("mult_rst", rd, `CEC_MULT_RST);
        wb(1'b0, 8'h10, 0);
        check("unmapped", rd, 0);
        // all config codes and stop levels, ext-on tried, then random
        for (int i = 0; i < 32; i++) begin
            wr(`CEC_CFG_OFS, ($urandom & 32'hFFFF_FFF8) | i[2:0]);
            wr(`CEC_CTRL_OFS, i[4] ? $urandom : 32'h7);
            stop_m = i[3];
            stop_mode_i <= i[3];
            pins;
        end
        // leave stop mode, or the internal generator stays halted
        stop_m = 1'b0;
        stop_mode_i <= 1'b0;
        wr(`CEC_CFG_OFS, 0);
        wr(`CEC_CTRL_OFS, 1);
        foreach (nv[k]) ratio(nv[k]);
        // bus taken from the external source
        wr(`CEC_CFG_OFS, 2);
        wr(`CEC_CTRL_OFS, 7);
        pins;
        ratio(5);
        stop_test;
    end
    // a hang ends the run through the same closing task
    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        stop_test;
    end
endmodule : clock_enable_control_test
